//--- common/swd_pkg.sv
// constants, types and register map of the supply reset / window watchdog block
package swd_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 20;
  localparam int RST_TMO_MIN_US   = 65;
  localparam int WDU_DFLT_US      = 200;
  localparam int GLT_NS           = 2000;
  localparam int RST_TMO_CYC      = RST_TMO_MIN_US * CLK_MHZ;
  localparam int WDU_CYC          = WDU_DFLT_US * CLK_MHZ;
  localparam int GLT_CYC          = (GLT_NS * CLK_MHZ + 999) / 1000;
  localparam int TW               = 24;
  localparam int GW               = 8;
  localparam int LOWER_SHIFT      = 4;
  localparam int HOLD_SHIFT       = 3;
  localparam logic [TW-1:0] RST_TMO_RST = TW'(RST_TMO_CYC);
  localparam logic [TW-1:0] WDU_RST     = TW'(WDU_CYC);
  localparam logic [GW-1:0] GLT_LAST    = GW'(GLT_CYC - 1);
  localparam logic [1:0]    FAST_LIMIT  = 2'h2;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] ADR_RST_TMO = 8'h00;
  localparam logic [AW-1:0] ADR_WDU     = 8'h04;
  localparam logic [AW-1:0] ADR_STAT    = 8'h08;
  localparam logic [AW-1:0] ADR_MASK    = 8'h0C;
  localparam logic [AW-1:0] ADR_STATE   = 8'h10;
  localparam logic [2:0]    HSIZE_WORD  = 3'h2;
  localparam logic [3:0]    MASK_RST    = 4'h0;
  localparam logic [31:0]   RD_ZERO     = 32'h0000_0000;

  // synchroniser layout: ch1, ch2, kick, enable_n, select[1:0]
  localparam int SW = 6;
  localparam logic [SW-1:0] SYNC_RST = 6'h08;
  localparam int S_CH1  = 5;
  localparam int S_CH2  = 4;
  localparam int S_KICK = 3;
  localparam int S_EN_N = 2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_LOW  = 2'b00,
    SEQ_HIGH = 2'b01,
    SEQ_OPEN = 2'b10
  } swd_seq_t;

  typedef enum logic [1:0] {
    WD_IDLE   = 2'b00,
    WD_WINDOW = 2'b01,
    WD_HOLD   = 2'b10
  } swd_wd_t;

  typedef struct packed {
    logic ch2_drop;
    logic ch1_drop;
    logic slow;
    logic fast;
  } swd_evt_t;

  typedef struct packed {
    logic          valid;
    logic          write;
    logic [AW-1:0] addr;
  } swd_aph_t;

endpackage : swd_pkg

//--- rtl/swd_top.sv
// supply reset supervisor with window watchdog and ahb-lite register slave
//
// How it works
// [R1] reset outputs stay low while a monitored channel is below ninety percent
// [R2] after recovery the reset timer runs; reset releases only after full timeout
// [R3] supply invalid during timeout clears timer; next valid starts a fresh timeout
// [R4] comparator changes need glitch-filter duration of persistence before acting
// [R5] only kick falling edges service the watchdog
// [R6] more than two kick edges inside fast period drive fault low
// [R7] no kick edge within slow period drives fault low
// [R8] lower bound is upper bound over sixteen; both follow one setting
// [R9] fault holdoff of upper over eight ignores kicks, then fault releases high
// [R10] processor kicks with period between fast and slow limits
// [R11] enable input switches watchdog; low, the undriven default, means enabled
// [R12] kick idles high when undriven; no edge seen while disabled
// [R13] select high: ch2 after ch1 valid, own timers, watchdog after both expire
// [R14] select low: ch2 after ch1, one timer once both valid releases both
// [R15] select open: both start, own timers, watchdog after channel 1 timer
// [R16] reset timeout defaults to sixty-five microseconds of clock cycles
// [R17] window upper bound defaults to two hundred microseconds of clock cycles
// [R18] all periods are counters with programmable limits except the fixed glitch filter; comparators are synchronised
//
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module swd_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  input  wire logic        channel1_output_ok,
  input  wire logic        channel2_output_ok,
  input  wire logic [1:0]  seq_select,
  input  wire logic        watchdog_kick,
  input  wire logic        watchdog_enable_n,
  output var  logic        channel1_reset_n,
  output var  logic        channel2_reset_n,
  output var  logic        channel2_start,
  output var  logic        watchdog_fault_n,
  output var  logic        irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [swd_pkg::TW-1:0] tmr_step(input logic run,
                                                       input logic [swd_pkg::TW-1:0] cnt,
                                                       input logic [swd_pkg::TW-1:0] lim);
    if (!run) begin
      tmr_step = '0;
    end else if (cnt >= lim) begin
      tmr_step = cnt;
    end else begin
      tmr_step = swd_pkg::TW'(cnt + 1'b1);
    end
  endfunction : tmr_step

  function automatic logic at_last(input logic [swd_pkg::TW-1:0] cnt,
                                   input logic [swd_pkg::TW-1:0] lim);
    at_last = (swd_pkg::TW'(cnt + 1'b1) >= lim);
  endfunction : at_last

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [swd_pkg::SW-1:0] sync1_r;
  logic [swd_pkg::SW-1:0] sync2_r;
  logic                   kick_d_r;
  logic                   kick_fall;
  logic [1:0]             ok_raw;
  logic [1:0]             ok_f_r;
  logic [swd_pkg::GW-1:0] glt_cnt_r [2];
  swd_pkg::swd_seq_t      mode;
  logic [swd_pkg::TW-1:0] rst_tmo_r;
  logic [swd_pkg::TW-1:0] wdu_r;
  logic [swd_pkg::TW-1:0] wdl;
  logic [swd_pkg::TW-1:0] hold;
  logic [swd_pkg::TW-1:0] tmr1_r;
  logic [swd_pkg::TW-1:0] tmr2_r;
  logic                   run1;
  logic                   run2;
  logic                   done1;
  logic                   done2;
  logic                   channel1_reset_n_nxt;
  logic                   channel2_reset_n_nxt;
  logic                   wd_start;
  logic                   wd_run;
  swd_pkg::swd_wd_t       wd_state_r;
  logic [swd_pkg::TW-1:0] wd_cnt_r;
  logic [1:0]             wd_edges_r;
  logic                   fast_hit;
  logic                   slow_hit;
  swd_pkg::swd_evt_t      evt;
  logic [3:0]             stat_r;
  logic [3:0]             stat_nxt;
  logic [3:0]             mask_r;
  swd_pkg::swd_aph_t      aph_r;
  logic                   accept;
  logic                   stat_rd;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= swd_pkg::SYNC_RST;
      sync2_r <= swd_pkg::SYNC_RST;
    end else begin
      sync1_r <= {channel1_output_ok, channel2_output_ok, watchdog_kick, watchdog_enable_n, seq_select}; // R18
      sync2_r <= sync1_r;
    end
  end

  assign ok_raw = {sync2_r[swd_pkg::S_CH2], sync2_r[swd_pkg::S_CH1]};
  assign mode   = swd_pkg::swd_seq_t'(sync2_r[1:0]);

  // kick idles high, so reset state shows no edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kick_d_r <= 1'b1; // R12
    end else begin
      kick_d_r <= sync2_r[swd_pkg::S_KICK];
    end
  end

  assign kick_fall = kick_d_r & ~sync2_r[swd_pkg::S_KICK]; // R5

  // ----------------------------------------------------------------
  // anti-glitch filter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ok_f_r       <= 2'h0;
      glt_cnt_r[0] <= '0;
      glt_cnt_r[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ok_raw[i] != ok_f_r[i]) begin
          if (glt_cnt_r[i] == swd_pkg::GLT_LAST) begin
            ok_f_r[i]    <= ok_raw[i]; // R4
            glt_cnt_r[i] <= '0;
          end else begin
            glt_cnt_r[i] <= swd_pkg::GW'(glt_cnt_r[i] + 1'b1);
          end
        end else begin
          glt_cnt_r[i] <= '0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencing and reset timers
  // ----------------------------------------------------------------
  always_comb begin
    run1 = ok_f_r[0];
    run2 = ok_f_r[1];
    unique case (mode)
      swd_pkg::SEQ_HIGH: begin
        run2 = ok_f_r[1] & ok_f_r[0]; // R13
      end
      swd_pkg::SEQ_LOW: begin
        run1 = ok_f_r[0] & ok_f_r[1]; // R14
        run2 = 1'b0;
      end
      default: begin
        run1 = ok_f_r[0]; // R15
        run2 = ok_f_r[1];
      end
    endcase
  end

  assign done1 = run1 & (tmr1_r >= rst_tmo_r); // R2
  assign done2 = run2 & (tmr2_r >= rst_tmo_r);

  always_comb begin
    channel1_reset_n_nxt = done1; // R1
    channel2_reset_n_nxt = done2;
    wd_start = done1; // R15
    unique case (mode)
      swd_pkg::SEQ_HIGH: begin
        wd_start = done1 & done2; // R13
      end
      swd_pkg::SEQ_LOW: begin
        channel2_reset_n_nxt = done1; // R14
      end
      default: begin
        wd_start = done1;
      end
    endcase
  end

  assign wd_run = wd_start & ~sync2_r[swd_pkg::S_EN_N]; // R11

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr1_r <= '0;
      tmr2_r <= '0;
    end else begin
      tmr1_r <= tmr_step(run1, tmr1_r, rst_tmo_r); // R3
      tmr2_r <= tmr_step(run2, tmr2_r, rst_tmo_r); // R3
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel1_reset_n <= 1'b0;
      channel2_reset_n <= 1'b0;
      channel2_start   <= 1'b0;
    end else begin
      channel1_reset_n <= channel1_reset_n_nxt; // R1
      channel2_reset_n <= channel2_reset_n_nxt; // R1
      channel2_start   <= (mode == swd_pkg::SEQ_HIGH || mode == swd_pkg::SEQ_LOW) ? ok_f_r[0] : 1'b1; // R13 R14
    end
  end

  // ----------------------------------------------------------------
  // window watchdog
  // ----------------------------------------------------------------
  assign wdl  = wdu_r >> swd_pkg::LOWER_SHIFT; // R8
  assign hold = wdu_r >> swd_pkg::HOLD_SHIFT;  // R9

  assign fast_hit = wd_run && wd_state_r == swd_pkg::WD_WINDOW && kick_fall && wd_cnt_r < wdl
                    && wd_edges_r == swd_pkg::FAST_LIMIT; // R6
  assign slow_hit = wd_run && wd_state_r == swd_pkg::WD_WINDOW && !kick_fall && at_last(wd_cnt_r, wdu_r); // R7

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_state_r       <= swd_pkg::WD_IDLE;
      wd_cnt_r         <= '0;
      wd_edges_r       <= 2'h0;
      watchdog_fault_n <= 1'b1;
    end else if (!wd_run) begin
      wd_state_r       <= swd_pkg::WD_IDLE; // R11
      wd_cnt_r         <= '0;
      wd_edges_r       <= 2'h0;
      watchdog_fault_n <= 1'b1;
    end else begin
      unique case (wd_state_r)
        swd_pkg::WD_IDLE: begin
          wd_state_r <= swd_pkg::WD_WINDOW;
          wd_cnt_r   <= '0;
          wd_edges_r <= 2'h0;
        end
        swd_pkg::WD_WINDOW: begin
          if (fast_hit || slow_hit) begin
            wd_state_r       <= swd_pkg::WD_HOLD; // R6 R7
            wd_cnt_r         <= '0;
            watchdog_fault_n <= 1'b0;
          end else if (kick_fall && wd_cnt_r < wdl) begin
            wd_edges_r <= 2'(wd_edges_r + 1'b1); // R6
            wd_cnt_r   <= swd_pkg::TW'(wd_cnt_r + 1'b1);
          end else if (kick_fall) begin
            wd_cnt_r   <= '0; // R5
            wd_edges_r <= 2'h0;
          end else begin
            wd_cnt_r <= swd_pkg::TW'(wd_cnt_r + 1'b1);
          end
        end
        swd_pkg::WD_HOLD: begin
          if (at_last(wd_cnt_r, hold)) begin
            wd_state_r       <= swd_pkg::WD_WINDOW; // R9
            wd_cnt_r         <= '0;
            wd_edges_r       <= 2'h0;
            watchdog_fault_n <= 1'b1;
          end else begin
            wd_cnt_r <= swd_pkg::TW'(wd_cnt_r + 1'b1); // R9
          end
        end
        default: begin
          wd_state_r <= swd_pkg::WD_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // events, status and interrupt
  // ----------------------------------------------------------------
  assign evt.fast     = fast_hit;
  assign evt.slow     = slow_hit;
  assign evt.ch1_drop = channel1_reset_n & ~channel1_reset_n_nxt;
  assign evt.ch2_drop = channel2_reset_n & ~channel2_reset_n_nxt;

  // set wins over read-clear
  assign stat_nxt = (stat_rd ? 4'h0 : stat_r) | evt;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= 4'h0;
      irq    <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq    <= |(stat_nxt & mask_r);
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  function automatic logic [31:0] rd_mux(input logic [swd_pkg::AW-1:0] a);
    rd_mux = swd_pkg::RD_ZERO;
    unique case (a)
      swd_pkg::ADR_RST_TMO: rd_mux[swd_pkg::TW-1:0] = rst_tmo_r;
      swd_pkg::ADR_WDU:     rd_mux[swd_pkg::TW-1:0] = wdu_r;
      swd_pkg::ADR_STAT:    rd_mux[3:0] = stat_r;
      swd_pkg::ADR_MASK:    rd_mux[3:0] = mask_r;
      swd_pkg::ADR_STATE:   rd_mux[7:0] = {wd_state_r, watchdog_fault_n, channel2_start,
                                           channel2_reset_n, channel1_reset_n, ok_f_r};
      default:              rd_mux = swd_pkg::RD_ZERO;
    endcase
  endfunction : rd_mux

  assign accept  = hsel & hready & htrans[1] & (hsize == swd_pkg::HSIZE_WORD);
  assign stat_rd = accept & ~hwrite & (haddr[swd_pkg::AW-1:0] == swd_pkg::ADR_STAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r     <= '0;
      hrdata    <= swd_pkg::RD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      aph_r     <= '{valid: accept, write: hwrite, addr: haddr[swd_pkg::AW-1:0]};
      hrdata    <= (accept && !hwrite) ? rd_mux(haddr[swd_pkg::AW-1:0]) : swd_pkg::RD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_tmo_r <= swd_pkg::RST_TMO_RST; // R16
      wdu_r     <= swd_pkg::WDU_RST;     // R17
      mask_r    <= swd_pkg::MASK_RST;
    end else if (aph_r.valid && aph_r.write) begin
      if (aph_r.addr == swd_pkg::ADR_RST_TMO) begin
        rst_tmo_r <= hwdata[swd_pkg::TW-1:0]; // R18
      end
      if (aph_r.addr == swd_pkg::ADR_WDU) begin
        wdu_r <= hwdata[swd_pkg::TW-1:0]; // R8 R18
      end
      if (aph_r.addr == swd_pkg::ADR_MASK) begin
        mask_r <= hwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_rst_low_invalid: assert property (!ok_f_r[0] |=> !channel1_reset_n) // R1
    else $error("channel 1 reset released while supply invalid");
  chk_release_full_tmo: assert property ($rose(channel1_reset_n) |-> $past(tmr1_r) >= rst_tmo_r) // R2
    else $error("channel 1 reset released before full timeout");
  chk_timer_restart: assert property ($fell(ok_f_r[0]) |=> tmr1_r == '0) // R3
    else $error("reset timer not cleared on invalid supply");
  chk_glitch_persist: assert property ($changed(ok_f_r[0]) |-> $past(glt_cnt_r[0]) == swd_pkg::GLT_LAST) // R4
    else $error("monitor state changed before glitch filter time");
  chk_fast_fault: assert property (fast_hit |=> !watchdog_fault_n && wd_state_r == swd_pkg::WD_HOLD) // R6
    else $error("third fast kick did not raise fault");
  chk_slow_fault: assert property (wd_run && wd_state_r == swd_pkg::WD_WINDOW && !kick_fall // R7
                                   && wd_cnt_r == swd_pkg::TW'(wdu_r - 1'b1) |=> !watchdog_fault_n)
    else $error("missing kick did not raise fault at upper bound");
  chk_window_ratio: assert property (wd_run && wd_state_r == swd_pkg::WD_WINDOW && kick_fall // R8
                                     && wd_cnt_r >= (wdu_r >> swd_pkg::LOWER_SHIFT)
                                     |=> wd_cnt_r == '0 && watchdog_fault_n)
    else $error("kick after lower bound not accepted");
  chk_holdoff_end: assert property (wd_run && wd_state_r == swd_pkg::WD_HOLD // R9
                                    && wd_cnt_r == swd_pkg::TW'((wdu_r >> swd_pkg::HOLD_SHIFT) - 1'b1) ##1 wd_run
                                    |-> watchdog_fault_n)
    else $error("fault not released after holdoff");
  chk_wd_idle_high: assert property (!wd_run |=> watchdog_fault_n && wd_state_r == swd_pkg::WD_IDLE) // R11
    else $error("fault asserted while watchdog not running");
  chk_seq_ch2_wait: assert property ((mode == swd_pkg::SEQ_HIGH || mode == swd_pkg::SEQ_LOW) && !ok_f_r[0] // R13
                                     |=> !channel2_start)
    else $error("channel 2 started before channel 1 valid");
  chk_low_shared: assert property (mode == swd_pkg::SEQ_LOW |=> channel1_reset_n == channel2_reset_n) // R14
    else $error("shared timer mode released resets apart");

  cov_fast_fault:   cover property (fast_hit);
  cov_slow_fault:   cover property (slow_hit);
  cov_rst_release:  cover property ($rose(channel2_reset_n));
  cov_pulse_train:  cover property ($rose(watchdog_fault_n) ##[1:1000] $fell(watchdog_fault_n));

endmodule : swd_top

`default_nettype wire

//--- dv/swd_cpu_model.sv
// processor model: kicks the watchdog at a set period, idles the kick high
`timescale 1ns/1ps
`default_nettype none

module swd_cpu_model (
  input  wire logic       hclk,
  input  wire logic       channel1_reset_n,
  input  wire logic       run,
  input  wire logic [7:0] period,
  output var  logic       watchdog_kick
);
  logic [7:0] cnt_r;

  // --------------------------------------------------------------
  // kick generator
  // --------------------------------------------------------------
  initial watchdog_kick = 1'b1;

  always @(posedge hclk) begin
    if (!run || !channel1_reset_n) begin
      cnt_r         <= 8'h00;
      watchdog_kick <= 1'b1;
    end else begin
      cnt_r         <= (cnt_r >= period - 8'h01) ? 8'h00 : cnt_r + 8'h01;
      watchdog_kick <= (cnt_r >= 8'h02);
    end
  end
endmodule : swd_cpu_model

`default_nettype wire

//--- dv/tb_top.sv
// testbench for the supply reset supervisor and window watchdog
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef struct {
    logic        wr;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } swd_row_t;

  logic        hclk, hresetn, hsel, hwrite, hready, ch1_ok, ch2_ok, enable_n, run;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, seq;
  logic [2:0]  hsize;
  logic [7:0]  period;
  logic        hreadyout, hresp, kick, channel1_reset_n_n, channel2_reset_n_n, ch2_start, fault_n, irq;
  int          err_count, num_checks, cyc, n;
  localparam int T  = 100;
  localparam int U  = 256;
  localparam int LO = T + swd_pkg::GLT_CYC;
  swd_row_t rows[9] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0000_0514},
    '{1'b0, 8'h04, 32'h0, 32'h0000_0FA0},
    '{1'b0, 8'h0C, 32'h0, 32'h0000_0000},
    '{1'b0, 8'h10, 32'h0, 32'h0000_0030},
    '{1'b1, 8'h00, 32'h64, 32'h0000_0064},
    '{1'b1, 8'h04, 32'h100, 32'h0000_0100},
    '{1'b1, 8'h0C, 32'hF, 32'h0000_000F},
    '{1'b1, 8'h14, 32'hFF, 32'h0000_0000},
    '{1'b1, 8'h10, 32'h0, 32'h0000_0030}};

  assign hready = hreadyout;

  swd_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .channel1_output_ok(ch1_ok), .channel2_output_ok(ch2_ok),
    .seq_select(seq), .watchdog_kick(kick), .watchdog_enable_n(enable_n),
    .channel1_reset_n(channel1_reset_n_n), .channel2_reset_n(channel2_reset_n_n), .channel2_start(ch2_start),
    .watchdog_fault_n(fault_n), .irq(irq));

  swd_cpu_model u_cpu (.hclk(hclk), .channel1_reset_n(channel1_reset_n_n), .run(run), .period(period),
    .watchdog_kick(kick));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk1

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    hsize  <= swd_pkg::HSIZE_WORD;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  function automatic logic sig(input int w);
    case (w)
      0:       return channel1_reset_n_n;
      1:       return channel2_reset_n_n;
      default: return fault_n;
    endcase
  endfunction : sig

  task automatic wait_lvl(input int w, input logic lvl, output int k);
    k = 0;
    while (sig(w) !== lvl && k < 5000) begin
      @(posedge hclk);
      k++;
    end
  endtask : wait_lvl

  task automatic hold(input int w, input logic lvl, input int c);
    int bad;
    bad = 0;
    repeat (c) begin
      @(posedge hclk);
      if (sig(w) !== lvl) bad++;
    end
    chk32(bad, 32'h0);
  endtask : hold

  task automatic reset_dut();
    @(posedge hclk);
    ch1_ok  <= 1'b0;
    ch2_ok  <= 1'b0;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, 8'h00, T, rd);
    bus(1'b1, 8'h04, U, rd);
    bus(1'b1, 8'h0C, 32'hF, rd);
  endtask : reset_dut

  // --------------------------------------------------------------
  // clock, timeout, stimulus
  // --------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    {hresetn, hsel, hwrite, ch1_ok, ch2_ok, run} = '0;
    {haddr, hwdata, htrans, hsize} = '0;
    enable_n = 1'b1;
    seq = swd_pkg::SEQ_OPEN;
    period = 8'h14;
    err_count = 0;
    num_checks = 0;
    cyc = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk1(channel1_reset_n_n | channel2_reset_n_n | irq | ~fault_n | hresp | ~hreadyout, 1'b0);
    foreach (rows[i]) begin
      if (rows[i].wr) bus(1'b1, rows[i].a, rows[i].d, rd);
      bus(1'b0, rows[i].a, 32'h0, rd);
      chk32(rd, rows[i].e);
      chk1(hresp, 1'b0);
    end
    $display("test registers done");
    // supply monitor: release, glitch, brownout, restart
    @(posedge hclk) ch1_ok <= 1'b1;
    wait_lvl(0, 1'b1, n);
    chk1(n >= LO && n <= LO + 6, 1'b1);
    @(posedge hclk) ch1_ok <= 1'b0;
    repeat (30) @(posedge hclk);
    ch1_ok <= 1'b1;
    hold(0, 1'b1, 60);
    @(posedge hclk) ch1_ok <= 1'b0;
    wait_lvl(0, 1'b0, n);
    chk1(n >= swd_pkg::GLT_CYC && n <= swd_pkg::GLT_CYC + 6, 1'b1);
    chk1(irq, 1'b1);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk32(rd, 32'h4);
    repeat (2) @(posedge hclk);
    chk1(irq, 1'b0);
    ch1_ok <= 1'b1;
    repeat (60) @(posedge hclk);
    ch1_ok <= 1'b0;
    hold(0, 1'b0, 60);
    ch1_ok <= 1'b1;
    wait_lvl(0, 1'b1, n);
    chk1(n >= LO && n <= LO + 6, 1'b1);
    $display("test supply done");
    // watchdog: good kicks, pulse train, fast kicks, disable
    enable_n <= 1'b0;
    run <= 1'b1;
    hold(2, 1'b1, 800);
    run <= 1'b0;
    wait_lvl(2, 1'b0, n);
    chk1(n <= U + 14, 1'b1);
    wait_lvl(2, 1'b1, n);
    chk1(n >= U / 8 - 1 && n <= U / 8 + 1, 1'b1);
    wait_lvl(2, 1'b0, n);
    chk1(n >= U - 1 && n <= U + 1, 1'b1);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk32(rd, 32'h2);
    wait_lvl(2, 1'b1, n);
    chk1(n >= U / 8 - 5 && n <= U / 8 - 1, 1'b1);
    period <= 8'h04;
    run <= 1'b1;
    wait_lvl(2, 1'b0, n);
    chk1(n <= U / 16 + 14, 1'b1);
    bus(1'b0, 8'h08, 32'h0, rd);
    chk32(rd, 32'h1);
    run <= 1'b0;
    enable_n <= 1'b1;
    repeat (6) @(posedge hclk);
    hold(2, 1'b1, 600);
    $display("test watchdog done");
    // sequencing modes
    enable_n <= 1'b0;
    seq <= swd_pkg::SEQ_LOW;
    reset_dut();
    chk1(channel1_reset_n_n | channel2_reset_n_n | irq | ~fault_n, 1'b0);
    ch1_ok <= 1'b1;
    repeat (200) @(posedge hclk);
    chk1(ch2_start, 1'b1);
    chk1(channel1_reset_n_n, 1'b0);
    ch2_ok <= 1'b1;
    wait_lvl(0, 1'b1, n);
    chk1(n >= LO && n <= LO + 6, 1'b1);
    chk1(channel2_reset_n_n, 1'b1);
    seq <= swd_pkg::SEQ_HIGH;
    reset_dut();
    repeat (4) @(posedge hclk);
    chk1(ch2_start, 1'b0);
    ch1_ok <= 1'b1;
    wait_lvl(0, 1'b1, n);
    chk1(n >= LO && n <= LO + 6, 1'b1);
    chk1(ch2_start, 1'b1);
    hold(2, 1'b1, 400);
    ch2_ok <= 1'b1;
    wait_lvl(1, 1'b1, n);
    chk1(n >= LO && n <= LO + 6, 1'b1);
    wait_lvl(2, 1'b0, n);
    chk1(n <= U + 14, 1'b1);
    seq <= swd_pkg::SEQ_OPEN;
    reset_dut();
    repeat (4) @(posedge hclk);
    chk1(ch2_start, 1'b1);
    ch1_ok <= 1'b1;
    wait_lvl(0, 1'b1, n);
    chk1(n >= LO && n <= LO + 6, 1'b1);
    wait_lvl(2, 1'b0, n);
    chk1(n <= U + 14, 1'b1);
    chk1(channel2_reset_n_n, 1'b0);
    $display("test sequencing done");
    conclude();
  end
endmodule : tb_top

`default_nettype wire
